// ---- logic/qdb_data_phase.sv ----
// quad-pumped data phase agent with per-group inversion, two clock domains
`include "qdb_consts.svh"
module qdb_data_phase (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     clk_en,
  input  wire logic [`QDB_WORD_W-1:0]   tx_word,
  input  wire logic                     tx_valid,
  output logic                          tx_ready,
  output logic [`QDB_LINE_W-1:0]        rx_line,
  output logic                          rx_strobe,
  input  wire logic                     link_clk,
  input  wire logic [`QDB_WORD_W-1:0]   bus_data_in,
  output logic [`QDB_WORD_W-1:0]        bus_data_out,
  output logic                          bus_data_oe,
  input  wire logic [`QDB_GROUPS-1:0]   group_invert_flags_in,
  output logic [`QDB_GROUPS-1:0]        group_invert_flags_out,
  output logic                          group_invert_flags_oe,
  input  wire logic [`QDB_GROUPS-1:0]   data_strobe_pos_in,
  output logic [`QDB_GROUPS-1:0]        data_strobe_pos_out,
  output logic                          data_strobe_pos_oe,
  input  wire logic [`QDB_GROUPS-1:0]   data_strobe_neg_in,
  output logic [`QDB_GROUPS-1:0]        data_strobe_neg_out,
  output logic                          data_strobe_neg_oe,
  input  wire logic                     data_valid_flag_in,
  output logic                          data_valid_flag_out,
  output logic                          data_valid_flag_oe,
  input  wire logic                     data_path_busy_in,
  output logic                          data_path_busy_out,
  output logic                          data_path_busy_oe
);
  // core side transmit and receive paths
  logic [`QDB_WORD_W-1:0] buf_data;   // word leaving buffer
  logic                   buf_valid;  // buffer has a word
  logic                   tx_full;    // line of four words collected
  logic                   tx_sent;    // line offered to link side
  logic [1:0]             tx_beat;    // next word slot in line
  logic [`QDB_LINE_W-1:0] tx_line;    // held stable while offered
  logic                   tx_req;     // toggles per offered line
  logic                   tx_ack_c1;  // ack synchroniser
  logic                   tx_ack_c2;
  logic                   rx_req_c1;  // receive request synchroniser
  logic                   rx_req_c2;
  logic                   rx_ack;     // toggles per taken line
  logic                   tx_ack;       // link toggles when a line is taken
  logic                   link_rx_req;  // link toggles per captured line
  logic [`QDB_LINE_W-1:0] link_rx_line; // held by the link until acked

  // buffer stall reaches tx_ready when the packer waits on the link
  qdb_pair_buf #(
    .WIDTH (`QDB_WORD_W),
    .DEPTH (`QDB_BUF_DEPTH)
  ) u_buf (
    .clk       (core_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_data   (tx_word),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (!tx_full)
  );

  // pack four words, then offer the line by toggling the request
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tx_beat <= 2'h0;
      tx_full <= 1'b0;
      tx_sent <= 1'b0;
      tx_req  <= 1'b0;
      tx_line <= '0;
    end
    else if (clk_en)
    begin
      // word 0 goes out first on the bus
      if (buf_valid && !tx_full)
      begin
        tx_line[{tx_beat, 6'h00} +: `QDB_WORD_W] <= buf_data;
        tx_beat <= tx_beat + 2'h1;
        if (tx_beat == `QDB_BEAT_LAST)
          tx_full <= 1'b1;
      end
      // offer once; free when the ack toggle comes back
      if (tx_full && !tx_sent && (tx_req == tx_ack_c2))
      begin
        tx_req  <= ~tx_req;
        tx_sent <= 1'b1;
      end
      else if (tx_sent && (tx_req == tx_ack_c2))
      begin
        tx_full <= 1'b0;
        tx_sent <= 1'b0;
      end
    end
  end

  // crossings into the core domain, two flops each
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tx_ack_c1 <= 1'b0;
      tx_ack_c2 <= 1'b0;
      rx_req_c1 <= 1'b0;
      rx_req_c2 <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_ack_c1 <= tx_ack;
      tx_ack_c2 <= tx_ack_c1;
      rx_req_c1 <= link_rx_req;
      rx_req_c2 <= rx_req_c1;
    end
  end

  // take a received line; the link holds it until acked
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rx_line   <= '0;
      rx_strobe <= 1'b0;
      rx_ack    <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_strobe <= 1'b0;
      if (rx_req_c2 != rx_ack)
      begin
        rx_line   <= link_rx_line;
        rx_strobe <= 1'b1;
        rx_ack    <= ~rx_ack;
      end
    end
  end

  // link side
  logic                      lrst_s1;      // reset carried into link domain
  logic                      link_rst;
  logic                      ce_s1;        // clock enable carried over
  logic                      link_en;
  logic                      tx_req_l1;    // request synchroniser
  logic                      tx_req_l2;
  logic                      rx_ack_l1;    // receive ack synchroniser
  logic                      rx_ack_l2;
  logic [3:0]                own_hist;     // our drive, aged like the pin filter
  logic [`QDB_LINE_W-1:0]    burst;        // line being driven
  logic [`QDB_CNT_W-1:0]     cnt;          // cycle in common clock
  qdb_pkg::qdb_tx_state_t    state;        // driver state
  logic                      tx_pending;   // core has a line for us
  logic                      drive;        // we own the path this cycle
  logic [`QDB_WORD_W-1:0]    cur_word;     // word of current slot
  logic [`QDB_WORD_W-1:0]    enc_word;     // after group inversion
  logic [`QDB_GROUPS-1:0]    enc_inv;      // group inverted flags
  logic [`QDB_PIN_W-1:0]     pin_raw;      // all pin inputs together
  logic [`QDB_PIN_W-1:0]     pin_s1;       // three flop pin pipeline
  logic [`QDB_PIN_W-1:0]     pin_s2;
  logic [`QDB_PIN_W-1:0]     pin_s3;
  logic [`QDB_PIN_W-1:0]     pin_acc;      // level once s2 and s3 agree
  logic [`QDB_GROUPS-1:0]    pos_prev;     // previous accepted strobes
  logic [`QDB_GROUPS-1:0]    neg_prev;
  logic [`QDB_LINE_W-1:0]    rx_cat;       // assembled receive line
  logic [`QDB_GROUPS-1:0]    grp_full;     // group has four beats
  logic                      rx_clear;     // restart group counters
  logic                      peer_busy;    // busy seen on the wire
  logic                      peer_valid;   // valid seen on the wire

  assign tx_pending = tx_req_l2 ^ tx_ack;
  assign drive      = (state == qdb_pkg::qdb_st_burst);
  assign cur_word   = burst[{cnt[2:1], 6'h00} +: `QDB_WORD_W];
  // pins are active low: a logic one is an electrical low
  assign pin_raw    = {data_path_busy_in, data_valid_flag_in, data_strobe_neg_in,
                       data_strobe_pos_in, group_invert_flags_in, bus_data_in};
  assign peer_busy  = ~pin_acc[`QDB_PIN_BUSY];
  assign peer_valid = ~pin_acc[`QDB_PIN_VALID];

  // asserted bits in one group
  function automatic logic [4:0] ones16(input logic [`QDB_GROUP_W-1:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < `QDB_GROUP_W; i++)
      n = n + {4'h0, v[i]};
    return n;
  endfunction

  // reset and enable into the link domain; these never freeze
  always_ff @(posedge link_clk)
  begin
    lrst_s1  <= reset;
    link_rst <= lrst_s1;
    ce_s1    <= clk_en;
    link_en  <= ce_s1;
  end

  // handshake synchronisers and pin pipeline
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      tx_req_l1 <= 1'b0;
      tx_req_l2 <= 1'b0;
      rx_ack_l1 <= 1'b0;
      rx_ack_l2 <= 1'b0;
      pin_s1    <= '1;
      pin_s2    <= '1;
      pin_s3    <= '1;
      pin_acc   <= '1;
      pos_prev  <= '1;
      neg_prev  <= '1;
      own_hist  <= 4'h0;
    end
    else if (link_en)
    begin
      tx_req_l1 <= tx_req;
      tx_req_l2 <= tx_req_l1;
      rx_ack_l1 <= rx_ack;
      rx_ack_l2 <= rx_ack_l1;
      pin_s1    <= pin_raw;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      // a bit changes only once two stages agree on it
      pin_acc   <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_acc & (pin_s2 ^ pin_s3));
      pos_prev  <= pin_acc[71:68];
      neg_prev  <= pin_acc[75:72];
      // our own last slots reach pin_acc only after oe has dropped
      own_hist  <= {own_hist[2:0], bus_data_oe};
    end
  end

  // driver: a burst starts only at a common clock boundary
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      cnt    <= '0;
      state  <= qdb_pkg::qdb_st_idle;
      burst  <= '0;
      tx_ack <= 1'b0;
    end
    else if (link_en)
    begin
      cnt <= cnt + 3'h1;
      if (cnt == `QDB_CNT_LAST)
      begin
        unique case (state)
          qdb_pkg::qdb_st_idle:
          begin
            // wait for another agent to release the path
            if (tx_pending && !peer_busy)
            begin
              burst  <= tx_line;
              tx_ack <= ~tx_ack;
              state  <= qdb_pkg::qdb_st_burst;
            end
          end
          qdb_pkg::qdb_st_burst:
          begin
            if (tx_pending)
            begin
              burst  <= tx_line;
              tx_ack <= ~tx_ack;
            end
            else
              state <= qdb_pkg::qdb_st_idle;
          end
        endcase
      end
    end
  end

  // per group inversion of the slot's word
  for (genvar g = 0; g < `QDB_GROUPS; g++)
  begin : gen_enc
    assign enc_inv[g] = (ones16(cur_word[g*16 +: 16]) > `QDB_INV_LIMIT);
    assign enc_word[g*16 +: 16] = enc_inv[g] ? ~cur_word[g*16 +: 16]
                                             : cur_word[g*16 +: 16];
  end

  // pin drivers; idle released lines sit electrically high
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      bus_data_out           <= '1;
      bus_data_oe            <= 1'b0;
      group_invert_flags_out <= '1;
      group_invert_flags_oe  <= 1'b0;
      data_strobe_pos_out    <= '1;
      data_strobe_pos_oe     <= 1'b0;
      data_strobe_neg_out    <= '1;
      data_strobe_neg_oe     <= 1'b0;
      data_valid_flag_out    <= 1'b1;
      data_valid_flag_oe     <= 1'b0;
      data_path_busy_out     <= 1'b1;
      data_path_busy_oe      <= 1'b0;
    end
    else if (link_en)
    begin
      // four slots of two cycles each per common clock
      bus_data_out           <= drive ? ~enc_word : '1;
      bus_data_oe            <= drive;
      group_invert_flags_out <= drive ? ~enc_inv : '1;
      group_invert_flags_oe  <= drive;
      // pos falls in slots 0 and 2, neg in slots 1 and 3
      data_strobe_pos_out    <= drive ? {4{cnt[1]}} : '1;
      data_strobe_pos_oe     <= drive;
      data_strobe_neg_out    <= drive ? {4{~cnt[1]}} : '1;
      data_strobe_neg_oe     <= drive;
      data_valid_flag_out    <= ~drive;
      data_valid_flag_oe     <= drive;
      data_path_busy_out     <= ~drive;
      data_path_busy_oe      <= drive;
    end
  end

  // receiver: each group latches on its own strobe pair
  for (genvar g = 0; g < `QDB_GROUPS; g++)
  begin : gen_rx
    logic [`QDB_GROUP_W-1:0] beats [0:`QDB_BEATS-1]; // captured beats
    logic [2:0]              got;                     // beats so far
    logic                    fall;                    // strobe edge seen
    // falling edge of either strobe of this group
    assign fall = (pos_prev[g] & ~pin_acc[68+g]) |
                  (neg_prev[g] & ~pin_acc[72+g]);
    assign grp_full[g] = (got == `QDB_CNT_FULL);

    // latch data and flag together, undo inversion
    always_ff @(posedge link_clk)
    begin
      if (link_rst)
        got <= 3'h0;
      else if (link_en)
      begin
        if (rx_clear)
          got <= 3'h0;
        else if (fall && peer_valid && !bus_data_oe && (own_hist == 4'h0)
                 && !grp_full[g])
        begin
          beats[got[1:0]] <= ~pin_acc[g*16 +: 16] ^ {16{~pin_acc[64+g]}};
          got <= got + 3'h1;
        end
      end
    end

    for (genvar b = 0; b < `QDB_BEATS; b++)
    begin : gen_beat
      assign rx_cat[b*64 + g*16 +: 16] = beats[b];
    end
  end

  // hand a complete line over; a line that finds the handshake busy waits
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      link_rx_req  <= 1'b0;
      link_rx_line <= '0;
      rx_clear     <= 1'b0;
    end
    else if (link_en)
    begin
      rx_clear <= 1'b0;
      if ((&grp_full) && !rx_clear && (link_rx_req == rx_ack_l2))
      begin
        link_rx_line <= rx_cat;
        link_rx_req  <= ~link_rx_req;
        rx_clear     <= 1'b1;
      end
    end
  end
endmodule // qdb_data_phase

// ---- logic/qdb_pair_buf.sv ----
// small valid/ready buffer in front of the transmit packer
`include "qdb_consts.svh"
module qdb_pair_buf #(
  parameter int WIDTH = `QDB_WORD_W,
  parameter int DEPTH = `QDB_BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [0:DEPTH-1]; // storage entries
  logic [PW-1:0]    wr_ptr;          // next slot to fill
  logic [PW-1:0]    rd_ptr;          // oldest entry
  logic [PW:0]      count;           // entries held
  logic [PW:0]      next_count;      // count after this cycle
  logic             push;            // entry accepted
  logic             pop;             // entry handed on

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // occupancy after this cycle
  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  // pointers and count; ready registered so it leaves a flop
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count    <= next_count;
      in_ready <= (next_count != (PW + 1)'(DEPTH));
    end
  end

  // entry write, no reset needed for data
  always_ff @(posedge clk)
  begin
    if (clk_en && push)
      mem[wr_ptr] <= in_data;
  end
endmodule // qdb_pair_buf

// ---- shared/qdb_consts.svh ----
// constants of the quad-pumped data phase with group inversion
// Summary of operation
// - all agents share one 64-bit data path
// - driver asserts data valid on each transfer
// - four data transfers per common clock
// - receiver latches on falling edge of both strobes
// - each 16-bit group has own strobe pair
// - one inversion line per 16-bit group
// - inversion lines travel and latch with data
// - invert group when more than half low
// - valid may drop to insert idle clocks
// - driver holds busy while using the path
`ifndef QDB_CONSTS_SVH
`define QDB_CONSTS_SVH

`define QDB_WORD_W     64
`define QDB_GROUPS     4
`define QDB_GROUP_W    16
`define QDB_BEATS      4
`define QDB_LINE_W     256
// link cycles per transfer slot, then the counter of the 8 link cycles per common clock
`define QDB_SLOT_CYC   2
`define QDB_CNT_W      3
`define QDB_CNT_LAST   3'h7
`define QDB_BEAT_LAST  2'h3
// more than this many asserted bits in a group triggers inversion
`define QDB_INV_LIMIT  5'h08
`define QDB_CNT_FULL   3'h4
`define QDB_BUF_DEPTH  2
// pin vector layout: data, flags, pos, neg, valid, busy
`define QDB_PIN_W      78
`define QDB_PIN_VALID  76
`define QDB_PIN_BUSY   77

`endif

// ---- shared/qdb_pkg.sv ----
// types shared by the data phase logic
package qdb_pkg;
  // link side driver state, one-hot
  typedef enum logic [1:0] {
    qdb_st_idle  = 2'h1,
    qdb_st_burst = 2'h2
  } qdb_tx_state_t;
endpackage

// ---- testbench/qdb_data_phase_sva.sv ----
// pin and core-side assertions for the quad-pumped data phase
`include "qdb_consts.svh"
module qdb_data_phase_sva (
  input wire logic                   core_clk,
  input wire logic                   reset,
  input wire logic                   clk_en,
  input wire logic [`QDB_LINE_W-1:0] rx_line,
  input wire logic                   rx_strobe,
  input wire logic                   link_clk,
  input wire logic [`QDB_WORD_W-1:0] bus_data_out,
  input wire logic                   bus_data_oe,
  input wire logic [`QDB_GROUPS-1:0] group_invert_flags_out,
  input wire logic                   group_invert_flags_oe,
  input wire logic [`QDB_GROUPS-1:0] data_strobe_pos_out,
  input wire logic                   data_strobe_pos_oe,
  input wire logic [`QDB_GROUPS-1:0] data_strobe_neg_out,
  input wire logic                   data_strobe_neg_oe,
  input wire logic                   data_valid_flag_out,
  input wire logic                   data_valid_flag_oe,
  input wire logic                   data_path_busy_out,
  input wire logic                   data_path_busy_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] en_hist; // enable seen on the link clock
  // an enable drop freezes the link side and stretches a slot, so skip slot timing
  always_ff @(posedge link_clk)
    if (reset)
      en_hist <= 4'h0;
    else
      en_hist <= {en_hist[2:0], clk_en};
  // encoded groups carry at most half ones; a flagged group strictly fewer
  function automatic bit grp_ok(logic [63:0] d, logic [3:0] f);
    bit ok;
    ok = 1;
    for (int g = 0; g < 4; g++)
      if ($countones(~d[g*16 +: 16]) > (f[g] ? 8 : 7)) ok = 0;
    return ok;
  endfunction
  // one slot: launch cycle, then data and flags hold with the strobes
  sequence s_slot(logic [3:0] p);
    (data_strobe_pos_out == p && data_strobe_neg_out == ~p) ##1
    (data_strobe_pos_out == p && $stable(bus_data_out) && $stable(group_invert_flags_out));
  endsequence
  property p_oe_group;
    @(posedge link_clk) disable iff (reset)
    {5{bus_data_oe}} == {group_invert_flags_oe, data_strobe_pos_oe, data_strobe_neg_oe,
                         data_valid_flag_oe, data_path_busy_oe};
  endproperty
  a_oe_group: assert property (p_oe_group) else $error("pin enables disagree");
  property p_valid_drv;
    @(posedge link_clk) disable iff (reset) bus_data_oe |-> !data_valid_flag_out;
  endproperty
  a_valid_drv: assert property (p_valid_drv) else $error("valid not low while driving");
  property p_busy_drv;
    @(posedge link_clk) disable iff (reset) bus_data_oe |-> !data_path_busy_out;
  endproperty
  a_busy_drv: assert property (p_busy_drv) else $error("busy not low while driving");
  property p_idle_high;
    @(posedge link_clk) disable iff (reset) !bus_data_oe |-> &{bus_data_out,
      group_invert_flags_out, data_strobe_pos_out, data_strobe_neg_out,
      data_valid_flag_out, data_path_busy_out};
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("released pins not high");
  property p_burst_len;
    @(posedge link_clk) disable iff (reset) $rose(bus_data_oe) |-> bus_data_oe [*8];
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst shorter than 8");
  property p_strobe_seq;
    @(posedge link_clk) disable iff (reset || !(&en_hist)) $rose(bus_data_oe) |->
      s_slot(4'h0) ##1 s_slot(4'hF) ##1 s_slot(4'h0) ##1 s_slot(4'hF);
  endproperty
  a_strobe_seq: assert property (p_strobe_seq) else $error("strobe pattern wrong");
  property p_inv_code;
    @(posedge link_clk) disable iff (reset)
    bus_data_oe |-> grp_ok(bus_data_out, group_invert_flags_out);
  endproperty
  a_inv_code: assert property (p_inv_code) else $error("group inversion wrong");
  property p_rx_pulse;
    @(posedge core_clk) disable iff (reset) rx_strobe && clk_en |=> !rx_strobe;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx strobe longer than one cycle");
  property p_rx_hold;
    @(posedge core_clk) disable iff (reset) $changed(rx_line) |-> rx_strobe;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx line changed without strobe");
endmodule // qdb_data_phase_sva

// ---- testbench/qdb_far_agent.sv ----
// far-side bus agent: decodes our bursts and sends bursts of its own
module qdb_far_agent (
  input  wire logic        link_clk,
  input  wire logic [63:0] data_w,
  input  wire logic [3:0]  flags_w,
  input  wire logic [3:0]  pos_w,
  input  wire logic [3:0]  neg_w,
  input  wire logic        valid_w,
  input  wire logic        busy_w,
  output logic      [63:0] f_data,
  output logic      [3:0]  f_flags,
  output logic      [3:0]  f_pos,
  output logic      [3:0]  f_neg,
  output logic             f_valid,
  output logic             f_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [255:0] got_q[$];       // decoded lines seen on the wire
  logic [255:0] acc;            // line under assembly
  logic [3:0]   pp   = 4'hF;    // positive strobes one edge back
  logic [3:0]   pn   = 4'hF;    // negative strobes one edge back
  logic         drv  = 1'b0;    // we own the path, so ignore the wire
  int           beat[4] = '{0, 0, 0, 0};
  // released lines float to the pull-up level
  initial {f_data, f_flags, f_pos, f_neg, f_valid, f_busy} = '1;
  // latch a group on a falling edge of either strobe of that group
  always @(posedge link_clk)
  begin
    for (int g = 0; g < 4; g++)
      if (!drv && !valid_w && ((pp[g] && !pos_w[g]) || (pn[g] && !neg_w[g])))
      begin
        // asserted flag: the sender complemented this group
        acc[beat[g]*64 + g*16 +: 16] = flags_w[g] ? ~data_w[g*16 +: 16] : data_w[g*16 +: 16];
        beat[g] = (beat[g] + 1) % 4;
        if (g == 3 && beat[3] == 0) got_q.push_back(acc);
      end
    pp = pos_w;
    pn = neg_w;
  end
  // one line: four words, two link cycles each, groups in inv complemented
  task automatic send_line(input logic [255:0] line, input logic [3:0] inv);
    logic [15:0] v;
    while (busy_w !== 1'b1) @(posedge link_clk);
    @(posedge link_clk);
    drv <= 1'b1;
    f_busy <= 1'b0;
    f_valid <= 1'b0;
    for (int s = 0; s < 8; s++)
    begin
      for (int g = 0; g < 4; g++)
      begin
        v = line[(s/2)*64 + g*16 +: 16] ^ {16{inv[g]}};
        f_data[g*16 +: 16] <= ~v;
        f_flags[g] <= ~inv[g];
      end
      f_pos <= (s % 4 < 2) ? 4'h0 : 4'hF;
      f_neg <= (s % 4 < 2) ? 4'hF : 4'h0;
      @(posedge link_clk);
    end
    drv <= 1'b0;
    {f_data, f_flags, f_pos, f_neg, f_valid, f_busy} <= '1;
  endtask
endmodule // qdb_far_agent

// ---- testbench/testbench.sv ----
// self-checking bench: core words out over the bus, far-agent lines in
`include "qdb_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic         core_clk = 0, link_clk = 0, reset = 1, clk_en = 0, tx_valid = 0;
  logic [63:0]  tx_word = '0, d_data, f_data, w_data;
  logic [3:0]   d_flags, d_pos, d_neg, f_flags, f_pos, f_neg, w_flags, w_pos, w_neg;
  logic         d_valid, d_busy, f_valid, f_busy, w_valid, w_busy, tx_ready, rx_strobe;
  logic         oe_d, oe_f, oe_p, oe_n, oe_v, oe_b;
  logic [255:0] rx_line;
  logic [255:0] exp_tx[$], exp_rx[$];  // model queues of whole lines
  int           seed = 32'h3B2EC1A7, err_count = 0, n_compared = 0, refused = 0;
  always #12.5 core_clk = ~core_clk;
  always #7.5 link_clk = ~link_clk;
  // wired bus: either party pulls low, pull-up otherwise
  assign w_data  = ((oe_d === 1'b1) ? d_data : '1) & f_data;
  assign w_flags = ((oe_f === 1'b1) ? d_flags : '1) & f_flags;
  assign w_pos   = ((oe_p === 1'b1) ? d_pos : '1) & f_pos;
  assign w_neg   = ((oe_n === 1'b1) ? d_neg : '1) & f_neg;
  assign w_valid = ((oe_v === 1'b1) ? d_valid : 1'b1) & f_valid;
  assign w_busy  = ((oe_b === 1'b1) ? d_busy : 1'b1) & f_busy;
  qdb_data_phase dut_u (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_line(rx_line),
    .rx_strobe(rx_strobe), .link_clk(link_clk), .bus_data_in(w_data),
    .bus_data_out(d_data), .bus_data_oe(oe_d), .group_invert_flags_in(w_flags),
    .group_invert_flags_out(d_flags), .group_invert_flags_oe(oe_f),
    .data_strobe_pos_in(w_pos), .data_strobe_pos_out(d_pos), .data_strobe_pos_oe(oe_p),
    .data_strobe_neg_in(w_neg), .data_strobe_neg_out(d_neg), .data_strobe_neg_oe(oe_n),
    .data_valid_flag_in(w_valid), .data_valid_flag_out(d_valid), .data_valid_flag_oe(oe_v),
    .data_path_busy_in(w_busy), .data_path_busy_out(d_busy), .data_path_busy_oe(oe_b));
  qdb_far_agent partner_u (.link_clk(link_clk), .data_w(w_data), .flags_w(w_flags),
    .pos_w(w_pos), .neg_w(w_neg), .valid_w(w_valid), .busy_w(w_busy), .f_data(f_data),
    .f_flags(f_flags), .f_pos(f_pos), .f_neg(f_neg), .f_valid(f_valid), .f_busy(f_busy));
  // one compare for every kind of result
  task automatic cmp(input string what, input logic [255:0] exp, input logic [255:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // groups biased to inversion boundaries: 0, 8, 9 and 16 ones
  function automatic logic [63:0] rnd_word();
    logic [63:0] w;
    for (int g = 0; g < 4; g++)
      case ($unsigned($random(seed)) % 6)
        0: w[g*16 +: 16] = 16'h0000;
        1: w[g*16 +: 16] = 16'hFFFF;
        2: w[g*16 +: 16] = 16'h00FF;
        3: w[g*16 +: 16] = 16'h01FF;
        default: w[g*16 +: 16] = 16'($random(seed));
      endcase
    return w;
  endfunction
  // offers n words with random gaps and enable drops; packs the model lines
  task automatic tx_phase(input int n);
    int          nw;
    logic [255:0] cur;
    nw = 0;
    while (nw < n)
    begin
      @(posedge core_clk);
      if (tx_valid && !tx_ready) refused++;
      if (tx_valid && tx_ready && clk_en)
      begin
        cur = {tx_word, cur[255:64]};
        nw++;
        if (nw % 4 == 0) exp_tx.push_back(cur);
      end
      if (!tx_valid || (tx_ready && clk_en))
      begin
        tx_valid <= nw < n && ($random(seed) & 3) != 0;
        tx_word <= rnd_word();
      end
      clk_en <= ($random(seed) & 7) != 0;
    end
  endtask
  // decoded inbound lines against the model, one per strobe
  always @(posedge core_clk)
    if (!reset && clk_en && rx_strobe === 1'b1)
      cmp("rx_line", exp_rx.size() ? exp_rx.pop_front() : 'x, rx_line);
  initial
  begin
    logic [255:0] line;
    repeat (5) @(posedge core_clk);
    reset <= 0;
    clk_en <= 1;
    tx_phase(80);
    clk_en <= 1;
    for (int i = 0; i < 400 && partner_u.got_q.size() < exp_tx.size(); i++)
      @(posedge core_clk);
    cmp("tx_count", exp_tx.size(), partner_u.got_q.size());
    for (int i = 0; i < exp_tx.size(); i++)
      cmp("tx_line", exp_tx[i], partner_u.got_q[i]);
    cmp("tx_refused", 1, refused != 0);
    for (int i = 0; i < 16; i++)
    begin
      line = {rnd_word(), rnd_word(), rnd_word(), rnd_word()};
      exp_rx.push_back(line);
      partner_u.send_line(line, i[3:0]); // every inversion mask
      repeat (12) @(posedge link_clk);
    end
    repeat (20) @(posedge core_clk);
    cmp("rx_left", 0, exp_rx.size());
    finish_test();
  end
  // hang guard, well past the expected run length
  initial
  begin
    #300000;
    err_count++;
    finish_test();
  end
endmodule // testbench
bind qdb_data_phase qdb_data_phase_sva chk_u (.core_clk(core_clk), .reset(reset),
  .clk_en(clk_en), .rx_line(rx_line), .rx_strobe(rx_strobe), .link_clk(link_clk),
  .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
  .group_invert_flags_out(group_invert_flags_out), .group_invert_flags_oe(group_invert_flags_oe),
  .data_strobe_pos_out(data_strobe_pos_out), .data_strobe_pos_oe(data_strobe_pos_oe),
  .data_strobe_neg_out(data_strobe_neg_out), .data_strobe_neg_oe(data_strobe_neg_oe),
  .data_valid_flag_out(data_valid_flag_out), .data_valid_flag_oe(data_valid_flag_oe),
  .data_path_busy_out(data_path_busy_out), .data_path_busy_oe(data_path_busy_oe));
